// ===== hdl/ber_monitor.sv
// One bit error rate monitor: subtotal accumulation, sliding window and alarm state
`timescale 1ns/1ps
module ber_monitor
(
  input  wire logic                     core_clk, // Device clock
  input  wire logic                     reset,    // Asynchronous reset, active high
  input  wire lerm_pkg::ber_config_type cfg,      // Enable, modes and limits
  input  wire lerm_pkg::line_frame_type line,     // Per-frame parity error count
  output logic                          alarm,    // Alarm state
  output logic                          change    // Pulse on declare or removal
);
  import lerm_pkg::*;

  typedef struct packed {
    ber_state_type    state;
    logic [23:0]      frame_count;
    logic [11:0]      subtotal;
    logic [7:0][11:0] history;
    logic [5:0]       long_count;
    logic [17:0]      long_sum;
    logic             change;
  } monitor_state_type;

  monitor_state_type st;
  monitor_state_type next_st;

  // Add with a cap; a cap of all ones still stops the count from wrapping
  function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [11:0] b, input logic [11:0] lim);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (lim != SAT_DISABLE && s > {1'b0, lim})
      sat_add = lim;
    else if (s[12])
      sat_add = 12'hFFF;
    else
      sat_add = s[11:0];
  endfunction

  // ==========================================================================
  // Accumulation and threshold evaluation
  always_comb
  begin
    logic [11:0] frame_errs;
    logic [11:0] sub_new;
    logic [14:0] total;
    logic [17:0] long_new;
    frame_errs = 12'h000;
    sub_new = 12'h000;
    total = 15'h0000;
    long_new = 18'h00000;
    next_st = st;
    next_st.change = 1'b0;
    if (!cfg.enable)
    begin
      next_st = '0;
      next_st.state = WATCH_DECLARE;
    end
    else if (line.frame)
    begin
      // Per-frame cap unless the cap applies to the whole subtotal
      frame_errs = cfg.sat_scope ? line.errors : sat_add(12'h000, line.errors, cfg.sat_limit);
      sub_new = sat_add(st.subtotal, frame_errs, cfg.sat_scope ? cfg.sat_limit : SAT_DISABLE);
      if ({1'b0, st.frame_count} + 25'h0000001 >= {1'b0, cfg.period})
      begin
        next_st.frame_count = 24'h000000;
        next_st.subtotal = 12'h000;
        next_st.history = {st.history[6:0], sub_new};
        for (int i = 0; i < WINDOW_SUBTOTALS; i++)
          total = total + {3'b000, next_st.history[i]};
        long_new = st.long_sum + {6'h00, sub_new};
        next_st.long_sum = long_new;
        next_st.long_count = st.long_count + 6'h01;
        case (st.state)
          WATCH_DECLARE:
            if (total >= {3'b000, cfg.declare_limit})
            begin
              next_st.state = WATCH_CLEAR;
              next_st.change = 1'b1;
              next_st.long_sum = 18'h00000;
              next_st.long_count = 6'h00;
            end
          WATCH_CLEAR:
            if (cfg.clear_long)
            begin
              if (st.long_count == LONG_CLEAR_LAST)
              begin
                next_st.long_sum = 18'h00000;
                if (long_new < {6'h00, cfg.clear_limit})
                begin
                  next_st.state = WATCH_DECLARE;
                  next_st.change = 1'b1;
                end
              end
            end
            else if (total < {3'b000, cfg.clear_limit})
            begin
              next_st.state = WATCH_DECLARE;
              next_st.change = 1'b1;
            end
          default: next_st.state = WATCH_DECLARE;
        endcase
      end
      else
      begin
        next_st.frame_count = st.frame_count + 24'h000001;
        next_st.subtotal = sub_new;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign alarm = (st.state == WATCH_CLEAR);
  assign change = st.change;

  // ==========================================================================
  // Checks
  disabled_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    !cfg.enable |=> !alarm && !change && st.subtotal == 12'h000)
    else $error("monitor not held idle while disabled");

  change_alarm_a: assert property (@(posedge core_clk) disable iff (reset)
    change |-> alarm != $past(alarm))
    else $error("change pulse without alarm transition");
endmodule

// ===== hdl/line_error_rate_monitor.sv
// Line error rate monitor top: APB register file, sync nibble filter and two monitors
//
// Behaviour
// - Degrade enable set: accumulate line parity errors and evaluate degrade thresholds.
// - Degrade enable clear: stop degrade accumulation, return to declaration watching.
// - Clear select one clears failure over a window eight times the declare window.
// - Saturation scope zero caps per frame, one caps per subtotal.
// - Failure enable set: accumulate line parity errors and evaluate failure thresholds.
// - Failure enable clear: stop failure accumulation, return to declaration watching.
// - Filter on: sync register updates only after three equal nibbles in a row.
// - Filter off: every received nibble goes straight into the sync register.
// - Failure subtotal period is a 24-bit count of 8 kHz frames.
// - Evaluation window slides over eight subtotals.
// - 12-bit saturation limit caps counted errors; all ones disables it.
// - Declare failure when window total reaches or passes the declare limit.
// - Failure subtotal period spans three byte registers, low byte first.
// - Each 12-bit failure limit is a low byte plus four bits in a high register.
// - Remove failure when window total falls below the clear limit.
// - Failure change flag sets on declare or removal, clears when status read.
// - Sync new flag sets whenever a new value enters the sync register.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module line_error_rate_monitor
(
  input  wire logic                         core_clk,       // Device clock, 10 MHz
  input  wire logic                         reset,          // Asynchronous reset, active high
  input  wire lerm_pkg::apb_request_type    apb_req,        // APB request signals
  output logic [31:0]                       prdata,         // APB read data
  output logic                              pready,         // APB ready
  output logic                              pslverr,        // APB error, unmapped address
  input  wire lerm_pkg::line_frame_type     line,           // Frame strobe, errors, nibble
  input  wire lerm_pkg::degrade_limits_type degrade_limits, // Degrade period and limits
  output logic                              failure_alarm,  // Failure alarm state
  output logic                              degrade_alarm,  // Degrade alarm state
  output logic [3:0]                        sync_status     // Accepted sync nibble
);
  import lerm_pkg::*;

  // ==========================================================================
  // State of the register file and the nibble filter
  typedef struct packed {
    logic        enhanced_map_select;
    logic [7:0]  control;
    logic [23:0] period;
    logic [11:0] sat_limit;
    logic [11:0] declare_limit;
    logic [11:0] clear_limit;
    logic [3:0]  rx_sync;
    logic [3:0]  sync_candidate;
    logic [1:0]  sync_run;
    logic        sync_new;
    logic        fail_change;
    logic        deg_change;
    logic [31:0] rdata;
    logic        err;
  } regs_type;

  regs_type       st;
  regs_type       next_st;
  ber_config_type fail_cfg;
  ber_config_type deg_cfg;
  logic           fail_alarm_w;
  logic           fail_change_w;
  logic           deg_alarm_w;
  logic           deg_change_w;
  logic           setup_phase;
  logic           access_phase;
  logic [7:0]     idx;

  // True when the address names a register of the current map
  function automatic logic reg_hit(input logic [11:0] addr, input logic enhanced_map_select);
    logic [7:0] i;
    i = addr[9:2];
    reg_hit = 1'b0;
    if (addr[1:0] == 2'b00 && addr[11:10] == 2'b00)
    begin
      if (i == MODE_IDX)
        reg_hit = 1'b1;
      else if (enhanced_map_select && (i == RX_SYNC_IDX || i == STATUS_IDX || i == CONTROL_IDX))
        reg_hit = 1'b1;
      else if (enhanced_map_select && i >= PERIOD_LOW_IDX && i <= CLEAR_HIGH_IDX)
        reg_hit = 1'b1;
    end
  endfunction

  // Read value of one byte register, zero above the documented bits
  function automatic logic [7:0] reg_value(input logic [7:0] i, input regs_type s,
                                           input logic fa, input logic da);
    case (i)
      MODE_IDX:         reg_value = {7'h00, s.enhanced_map_select};
      RX_SYNC_IDX:      reg_value = {4'h0, s.rx_sync};
      STATUS_IDX:       reg_value = {2'b00, s.sync_new, s.fail_change, s.deg_change, fa, da, 1'b0};
      CONTROL_IDX:      reg_value = {s.control[7:1], 1'b0};
      PERIOD_LOW_IDX:   reg_value = s.period[7:0];
      PERIOD_MID_IDX:   reg_value = s.period[15:8];
      PERIOD_HIGH_IDX:  reg_value = s.period[23:16];
      SAT_LOW_IDX:      reg_value = s.sat_limit[7:0];
      SAT_HIGH_IDX:     reg_value = {4'h0, s.sat_limit[11:8]};
      DECLARE_LOW_IDX:  reg_value = s.declare_limit[7:0];
      DECLARE_HIGH_IDX: reg_value = {4'h0, s.declare_limit[11:8]};
      CLEAR_LOW_IDX:    reg_value = s.clear_limit[7:0];
      CLEAR_HIGH_IDX:   reg_value = {4'h0, s.clear_limit[11:8]};
      default:          reg_value = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // Bus phases; the slave never waits
  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_phase = apb_req.psel && apb_req.penable;
  assign idx = apb_req.paddr[9:2];
  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign pslverr = st.err && access_phase;

  // ==========================================================================
  // Monitor configuration: control bits and failure limits from the register file, degrade limits from the input port
  always_comb
  begin
    fail_cfg.enable = st.control[CTL_FAIL_EN_BIT];
    fail_cfg.clear_long = st.control[CTL_FAIL_CLEAR_BIT];
    fail_cfg.sat_scope = st.control[CTL_FAIL_SCOPE_BIT];
    fail_cfg.period = st.period;
    fail_cfg.sat_limit = st.sat_limit;
    fail_cfg.declare_limit = st.declare_limit;
    fail_cfg.clear_limit = st.clear_limit;
    deg_cfg.enable = st.control[CTL_DEG_EN_BIT];
    deg_cfg.clear_long = st.control[CTL_DEG_CLEAR_BIT];
    deg_cfg.sat_scope = st.control[CTL_DEG_SCOPE_BIT];
    deg_cfg.period = degrade_limits.period;
    deg_cfg.sat_limit = degrade_limits.sat_limit;
    deg_cfg.declare_limit = degrade_limits.declare_limit;
    deg_cfg.clear_limit = degrade_limits.clear_limit;
  end

  // Both monitors see the same per-frame error count
  ber_monitor failure_monitor
  (
    .core_clk (core_clk),
    .reset    (reset),
    .cfg      (fail_cfg),
    .line     (line),
    .alarm    (fail_alarm_w),
    .change   (fail_change_w)
  );

  ber_monitor degrade_monitor
  (
    .core_clk (core_clk),
    .reset    (reset),
    .cfg      (deg_cfg),
    .line     (line),
    .alarm    (deg_alarm_w),
    .change   (deg_change_w)
  );

  // ==========================================================================
  // Register writes, read capture, sticky flags and the nibble filter
  always_comb
  begin
    logic       status_read;
    logic       sync_take;
    logic [1:0] run;
    status_read = 1'b0;
    sync_take = 1'b0;
    run = st.sync_run;
    next_st = st;

    // Read data is captured in setup so that it comes from a flip-flop
    if (setup_phase)
    begin
      next_st.err = !reg_hit(apb_req.paddr, st.enhanced_map_select);
      next_st.rdata = next_st.err ? 32'h00000000 :
                      {24'h000000, reg_value(idx, st, fail_alarm_w, deg_alarm_w)};
    end

    if (access_phase && reg_hit(apb_req.paddr, st.enhanced_map_select))
    begin
      if (apb_req.pwrite)
      begin
        case (idx)
          MODE_IDX:         next_st.enhanced_map_select = apb_req.pwdata[MODE_ENH_BIT];
          CONTROL_IDX:      next_st.control = {apb_req.pwdata[7:1], 1'b0};
          PERIOD_LOW_IDX:   next_st.period[7:0] = apb_req.pwdata[7:0];
          PERIOD_MID_IDX:   next_st.period[15:8] = apb_req.pwdata[7:0];
          PERIOD_HIGH_IDX:  next_st.period[23:16] = apb_req.pwdata[7:0];
          SAT_LOW_IDX:      next_st.sat_limit[7:0] = apb_req.pwdata[7:0];
          SAT_HIGH_IDX:     next_st.sat_limit[11:8] = apb_req.pwdata[3:0];
          DECLARE_LOW_IDX:  next_st.declare_limit[7:0] = apb_req.pwdata[7:0];
          DECLARE_HIGH_IDX: next_st.declare_limit[11:8] = apb_req.pwdata[3:0];
          CLEAR_LOW_IDX:    next_st.clear_limit[7:0] = apb_req.pwdata[7:0];
          CLEAR_HIGH_IDX:   next_st.clear_limit[11:8] = apb_req.pwdata[3:0];
          default:          next_st.enhanced_map_select = st.enhanced_map_select;
        endcase
      end
      else
        status_read = (idx == STATUS_IDX);
    end

    // Sync nibble capture
    if (line.frame)
    begin
      if (!st.control[CTL_FILTER_BIT])
        sync_take = 1'b1;
      else
      begin
        if (line.sync_nibble == st.sync_candidate)
          run = (st.sync_run == SYNC_HOLD_FRAMES) ? st.sync_run : st.sync_run + 2'h1;
        else
          run = 2'h1;
        next_st.sync_candidate = line.sync_nibble;
        next_st.sync_run = run;
        sync_take = (run == SYNC_HOLD_FRAMES);
      end
    end
    if (sync_take)
      next_st.rx_sync = line.sync_nibble;

    // Only bits already shown to the reader are cleared, and a set always wins
    next_st.sync_new = (sync_take && line.sync_nibble != st.rx_sync) ||
                       (st.sync_new && !(status_read && st.rdata[ST_SYNC_NEW_BIT]));
    next_st.fail_change = fail_change_w ||
                          (st.fail_change && !(status_read && st.rdata[ST_FAIL_CHANGE_BIT]));
    next_st.deg_change = deg_change_w ||
                         (st.deg_change && !(status_read && st.rdata[ST_DEG_CHANGE_BIT]));
  end

  // State register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
      st.enhanced_map_select <= MODE_RESET;
      st.control <= CONTROL_RESET;
      st.period <= PERIOD_RESET;
      st.sat_limit <= LIMIT_RESET;
      st.declare_limit <= LIMIT_RESET;
      st.clear_limit <= LIMIT_RESET;
      st.rx_sync <= SYNC_RESET;
    end
    else
      st <= next_st;
  end

  assign failure_alarm = fail_alarm_w;
  assign degrade_alarm = deg_alarm_w;
  assign sync_status = st.rx_sync;

  // ==========================================================================
  // Checks
  fail_disable_a: assert property (@(posedge core_clk) disable iff (reset)
    !st.control[CTL_FAIL_EN_BIT] |=> !failure_alarm)
    else $error("failure alarm active while monitor disabled");

  deg_disable_a: assert property (@(posedge core_clk) disable iff (reset)
    !st.control[CTL_DEG_EN_BIT] |=> !degrade_alarm)
    else $error("degrade alarm active while monitor disabled");

  fail_flag_set_a: assert property (@(posedge core_clk) disable iff (reset)
    fail_change_w |=> st.fail_change)
    else $error("failure change flag not set on alarm change");

  fail_flag_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    access_phase && !apb_req.pwrite && idx == STATUS_IDX && reg_hit(apb_req.paddr, st.enhanced_map_select)
    && st.rdata[ST_FAIL_CHANGE_BIT] && !fail_change_w |=> !st.fail_change)
    else $error("failure change flag not cleared by status read");

  sync_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    (st.rx_sync != $past(st.rx_sync)) |-> st.sync_new)
    else $error("sync register changed without flag");

  sync_direct_a: assert property (@(posedge core_clk) disable iff (reset)
    line.frame && !st.control[CTL_FILTER_BIT] |=> st.rx_sync == $past(line.sync_nibble))
    else $error("unfiltered nibble not written");

  sync_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    line.frame && st.control[CTL_FILTER_BIT] && line.sync_nibble != st.sync_candidate |=> $stable(st.rx_sync))
    else $error("filtered sync register updated too early");

  period_high_a: assert property (@(posedge core_clk) disable iff (reset)
    access_phase && apb_req.pwrite && st.enhanced_map_select && apb_req.paddr == {2'b00, PERIOD_HIGH_IDX, 2'b00}
    |=> st.period[23:16] == $past(apb_req.pwdata[7:0]) && $stable(st.period[15:0]))
    else $error("period high byte not stored");

  limit_high_a: assert property (@(posedge core_clk) disable iff (reset)
    setup_phase && !apb_req.pwrite && st.enhanced_map_select && apb_req.paddr == {2'b00, DECLARE_HIGH_IDX, 2'b00}
    |=> prdata[7:4] == 4'h0 && prdata[3:0] == $past(st.declare_limit[11:8]))
    else $error("declare limit high register reads wrong");

  unmapped_a: assert property (@(posedge core_clk) disable iff (reset)
    setup_phase && !reg_hit(apb_req.paddr, st.enhanced_map_select) |=> pslverr || !access_phase)
    else $error("unmapped access without error");
endmodule

// ===== inc/lerm_pkg.sv
// Package: register map, field layout and carrier types of the line error rate monitor
package lerm_pkg;

  // ==========================================================================
  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] MODE_IDX        = 8'h0D;
  localparam logic [7:0] RX_SYNC_IDX     = 8'h1F;
  localparam logic [7:0] STATUS_IDX      = 8'h21;
  localparam logic [7:0] CONTROL_IDX     = 8'h22;
  localparam logic [7:0] PERIOD_LOW_IDX  = 8'h23;
  localparam logic [7:0] PERIOD_MID_IDX  = 8'h24;
  localparam logic [7:0] PERIOD_HIGH_IDX = 8'h25;
  localparam logic [7:0] SAT_LOW_IDX     = 8'h26;
  localparam logic [7:0] SAT_HIGH_IDX    = 8'h27;
  localparam logic [7:0] DECLARE_LOW_IDX = 8'h28;
  localparam logic [7:0] DECLARE_HIGH_IDX = 8'h29;
  localparam logic [7:0] CLEAR_LOW_IDX   = 8'h2A;
  localparam logic [7:0] CLEAR_HIGH_IDX  = 8'h2B;

  // ==========================================================================
  // Field positions
  localparam int MODE_ENH_BIT       = 0;
  localparam int CTL_FILTER_BIT     = 7;
  localparam int CTL_FAIL_EN_BIT    = 6;
  localparam int CTL_FAIL_SCOPE_BIT = 5;
  localparam int CTL_FAIL_CLEAR_BIT = 4;
  localparam int CTL_DEG_EN_BIT     = 3;
  localparam int CTL_DEG_SCOPE_BIT  = 2;
  localparam int CTL_DEG_CLEAR_BIT  = 1;
  localparam int ST_SYNC_NEW_BIT    = 5;
  localparam int ST_FAIL_CHANGE_BIT = 4;
  localparam int ST_DEG_CHANGE_BIT  = 3;
  localparam int ST_FAIL_ALARM_BIT  = 2;
  localparam int ST_DEG_ALARM_BIT   = 1;

  // ==========================================================================
  // Reset values and monitor constants
  localparam logic        MODE_RESET      = 1'b0;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [23:0] PERIOD_RESET    = 24'h000000;
  localparam logic [11:0] LIMIT_RESET     = 12'h000;
  localparam logic [3:0]  SYNC_RESET      = 4'h0;
  localparam logic [11:0] SAT_DISABLE     = 12'hFFF;
  localparam int          WINDOW_SUBTOTALS = 8;
  localparam int          CLEAR_WINDOW_FACTOR = 8;
  localparam logic [5:0]  LONG_CLEAR_LAST = 6'(WINDOW_SUBTOTALS * CLEAR_WINDOW_FACTOR - 1);
  localparam logic [1:0]  SYNC_HOLD_FRAMES = 2'h3;

  // ==========================================================================
  // Carrier types
  typedef enum logic [1:0] {WATCH_DECLARE = 2'b00, WATCH_CLEAR = 2'b01} ber_state_type;

  typedef struct packed {
    logic        enable;
    logic        clear_long;
    logic        sat_scope;
    logic [23:0] period;
    logic [11:0] sat_limit;
    logic [11:0] declare_limit;
    logic [11:0] clear_limit;
  } ber_config_type;

  typedef struct packed {
    logic        frame;
    logic [11:0] errors;
    logic [3:0]  sync_nibble;
  } line_frame_type;

  typedef struct packed {
    logic [23:0] period;
    logic [11:0] sat_limit;
    logic [11:0] declare_limit;
    logic [11:0] clear_limit;
  } degrade_limits_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_request_type;

endpackage

// ===== verif/tb_line_error_rate_monitor.sv
// Self-checking testbench of the line error rate monitor
`timescale 1ns/1ps
module tb_line_error_rate_monitor;
  import lerm_pkg::*;
  logic               core_clk = 1'b0;
  logic               reset = 1'b1;
  apb_request_type    apb_req = '0;
  line_frame_type     line = '0;
  degrade_limits_type degrade_limits = '0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               failure_alarm;
  logic               degrade_alarm;
  logic [3:0]         sync_status;
  logic [31:0]        rd;
  logic               err;
  int                 num_errors = 0;
  int                 n_tests = 0;

  // ==========================================================================
  // Clock and device
  always #50 core_clk = ~core_clk;

  line_error_rate_monitor i_dut
  (
    .core_clk       (core_clk),
    .reset          (reset),
    .apb_req        (apb_req),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .line           (line),
    .degrade_limits (degrade_limits),
    .failure_alarm  (failure_alarm),
    .degrade_alarm  (degrade_alarm),
    .sync_status    (sync_status)
  );

  // ==========================================================================
  // Shared tasks
  // Verdict in one place, so a hang ends the same way as a full run
  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // Request held from setup until the edge where ready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, wr, {2'b00, idx, 2'b00}, {24'h000000, d}};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      chk(32'h0, 32'h1, "no ready");
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp, "read data");
    chk({31'h0, err}, {31'h0, exp_err}, "slave error");
  endtask

  // Frames are spaced so alarm and flags have settled before any check
  task automatic frame(input int cnt, input logic [11:0] e, input logic [3:0] nib);
    repeat (cnt)
    begin
      @(posedge core_clk);
      line <= '{1'b1, e, nib};
      @(posedge core_clk);
      line.frame <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask

  // Monitor off while limits change, then on, then stale flags read away
  task automatic cfg(input logic [7:0] ctl, input logic [7:0] per, input logic [11:0] sat,
                     input logic [11:0] dcl, input logic [11:0] clr);
    apb(1'b1, CONTROL_IDX, 8'h00);
    apb(1'b1, PERIOD_LOW_IDX, per);
    apb(1'b1, SAT_LOW_IDX, sat[7:0]);
    apb(1'b1, SAT_HIGH_IDX, {4'h0, sat[11:8]});
    apb(1'b1, DECLARE_LOW_IDX, dcl[7:0]);
    apb(1'b1, DECLARE_HIGH_IDX, {4'h0, dcl[11:8]});
    apb(1'b1, CLEAR_LOW_IDX, clr[7:0]);
    apb(1'b1, CLEAR_HIGH_IDX, {4'h0, clr[11:8]});
    apb(1'b1, CONTROL_IDX, ctl);
    apb(1'b0, STATUS_IDX, 8'h00);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_map();
    rd_chk(CONTROL_IDX, 32'h0, 1'b1);
    apb(1'b1, MODE_IDX, 8'h01);
    rd_chk(8'h3F, 32'h0, 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      rd_chk(PERIOD_LOW_IDX + 8'(i), 32'h0, 1'b0);
      apb(1'b1, PERIOD_LOW_IDX + 8'(i), 8'hFF);
      rd_chk(PERIOD_LOW_IDX + 8'(i), (i == 4 || i == 6 || i == 8) ? 32'h0F : 32'hFF, 1'b0);
    end
    apb(1'b1, PERIOD_MID_IDX, 8'h00);
    apb(1'b1, PERIOD_HIGH_IDX, 8'h00);
  endtask

  task automatic t_declare();
    cfg(8'h40, 8'h01, 12'hFFF, 12'h005, 12'h003);
    frame(1, 12'h004, 4'h0);
    chk(failure_alarm, 32'h0, "below declare");
    frame(1, 12'h001, 4'h0);
    chk(failure_alarm, 32'h1, "declare at limit");
    rd_chk(STATUS_IDX, 32'h14, 1'b0);
    rd_chk(STATUS_IDX, 32'h04, 1'b0);
    frame(6, 12'h000, 4'h0);
    chk(failure_alarm, 32'h1, "eight subtotal window");
    frame(1, 12'h000, 4'h0);
    chk(failure_alarm, 32'h0, "removed below clear");
    rd_chk(STATUS_IDX, 32'h10, 1'b0);
  endtask

  // Disabled monitors must neither alarm nor keep history
  task automatic t_disable();
    degrade_limits <= '{24'h000001, 12'hFFF, 12'h002, 12'h001};
    apb(1'b1, CONTROL_IDX, 8'h48);
    frame(1, 12'h005, 4'h0);
    chk({failure_alarm, degrade_alarm}, 32'h3, "both declared");
    apb(1'b1, CONTROL_IDX, 8'h00);
    frame(1, 12'h005, 4'h0);
    chk({failure_alarm, degrade_alarm}, 32'h0, "off drops alarms");
    apb(1'b1, CONTROL_IDX, 8'h48);
    frame(1, 12'h000, 4'h0);
    chk({failure_alarm, degrade_alarm}, 32'h0, "no stale history");
  endtask

  task automatic t_sat();
    cfg(8'h40, 8'h01, 12'h002, 12'h005, 12'h001);
    frame(2, 12'h009, 4'h0);
    chk(failure_alarm, 32'h0, "frame cap");
    frame(1, 12'h009, 4'h0);
    chk(failure_alarm, 32'h1, "capped sum declares");
    cfg(8'h60, 8'h02, 12'h003, 12'h004, 12'h001);
    frame(2, 12'h002, 4'h0);
    chk(failure_alarm, 32'h0, "subtotal cap");
    frame(2, 12'h002, 4'h0);
    chk(failure_alarm, 32'h1, "second subtotal");
    cfg(8'h40, 8'h01, 12'hFFF, 12'h009, 12'h001);
    frame(1, 12'h009, 4'h0);
    chk(failure_alarm, 32'h1, "all ones no cap");
  endtask

  // Clear limit above the declared count, so only the window length decides
  task automatic t_long();
    cfg(8'h50, 8'h01, 12'hFFF, 12'h005, 12'h006);
    frame(1, 12'h005, 4'h0);
    frame(20, 12'h000, 4'h0);
    chk(failure_alarm, 32'h1, "long clear window");
    frame(50, 12'h000, 4'h0);
    chk(failure_alarm, 32'h0, "long window cleared");
  endtask

  task automatic t_sync();
    cfg(8'h00, 8'h01, 12'hFFF, 12'h005, 12'h001);
    frame(1, 12'h000, 4'hA);
    rd_chk(RX_SYNC_IDX, 32'h0A, 1'b0);
    rd_chk(STATUS_IDX, 32'h20, 1'b0);
    apb(1'b1, CONTROL_IDX, 8'h80);
    frame(2, 12'h000, 4'h3);
    frame(1, 12'h000, 4'h5);
    frame(2, 12'h000, 4'h3);
    chk(sync_status, 32'hA, "broken run held");
    frame(1, 12'h000, 4'h3);
    chk(sync_status, 32'h3, "third equal frame");
    rd_chk(STATUS_IDX, 32'h20, 1'b0);
  endtask

  // Mid-run reset returns the plain map and drops captured state
  task automatic t_reset();
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    chk({failure_alarm, degrade_alarm, sync_status}, 32'h0, "reset outputs");
    rd_chk(MODE_IDX, 32'h0, 1'b0);
    rd_chk(STATUS_IDX, 32'h0, 1'b1);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    t_map();
    t_declare();
    t_disable();
    t_sat();
    t_long();
    t_sync();
    t_reset();
    end_of_test();
  end
endmodule
